// File: src/sbm_map.svh
`ifndef SBM_MAP_SVH
`define SBM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SBM_OFS_BAUD    4'h0
`define SBM_OFS_FINE_TX 4'h1
`define SBM_OFS_FINE_RX 4'h2
`define SBM_OFS_CTRL    4'h3
`define SBM_OFS_STAT    4'h4
`define SBM_OFS_LIN_DIVIDER_HI 4'h5
`define SBM_OFS_LIN_DIVIDER_LO 4'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SBM_BAUD_PR_HI  7
`define SBM_BAUD_PR_LO  6
`define SBM_BAUD_TX_HI  5
`define SBM_BAUD_TX_LO  3
`define SBM_BAUD_RX_HI  2
`define SBM_BAUD_RX_LO  0
`define SBM_CTRL_MUTE   0
`define SBM_CTRL_WAKE   1
`define SBM_CTRL_LINE   2
`define SBM_CTRL_SLAVE  3
`define SBM_CTRL_HDM    4
`define SBM_CTRL_TXEN   5
`define SBM_CTRL_RXEN   6
`define SBM_STAT_FULL   0
`define SBM_STAT_QUIET  1
`define SBM_STAT_SYNC   2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SBM_RST_BYTE    8'h00
`define SBM_RST_LIN_DIVIDER    16'h0190

// ----------------------------------------
// Divider and timing counts
// ----------------------------------------
`define SBM_OVS_LAST    4'hF
`define SBM_PR_F0       4'h1
`define SBM_PR_F1       4'h3
`define SBM_PR_F2       4'h4
`define SBM_PR_F3       4'hD
`define SBM_SYNC_FALLS  3'h5
`define SBM_HOT_BITS    4'hB
`define SBM_MEAS_SHIFT  3

`endif

// File: src/sbm_pkg.sv
package sbm_pkg;

    typedef enum logic [1:0] {
        SBM_SYNC_IDLE,
        SBM_SYNC_ARMED,
        SBM_SYNC_COUNT
    } sbm_sync_t;

endpackage : sbm_pkg

// File: src/sbm_baud_wakeup.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "sbm_map.svh"

// What this block does
// - LIN synch field measured over eight bits
// - CPU-clock counter, one-cycle measurement resolution
// - LIN divider has sixteenth-step fraction
// - LIN slave wakes on break or identifier
// - LIN slave mute waits eleven dominant bits
// - Rates divide by 16, factor, ratio
// - Tx and rx ratios powers of two
// - Fine prescaler divides by 1 to 255
// - Fine prescaler active only when nonzero
// - Fine rate includes fine divider product
// - Mute blocks reception status flags
// - Mute suppresses all receive interrupts
// - Wake method picks idle or address
// - Idle wake clears mute, no quiet flag
// - Address mark wakes and sets full
// - LIN slave disables conventional generators
// - Mute write ignored while full, address
// - Fine prescalers zero after reset
module sbm_baud_wakeup #(
    parameter int MEAS_W = 19,
    parameter int MANT_W = 12
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        rx_input_line,
    input  wire logic        rx_word_done,
    input  wire logic        rx_word_msb,
    input  wire logic        rx_idle_frame,
    input  wire logic        lin_break_seen,
    input  wire logic        lin_ident_seen,
    output logic             tx_rate_tick,
    output logic             rx_rate_tick,
    output logic             rx_status_enable,
    output logic             rx_irq_enable,
    output logic             rx_discard,
    output logic             mute_control,
    output logic             rx_full_flag
);

    if (MEAS_W != MANT_W + 4 + `SBM_MEAS_SHIFT || MANT_W < 8 || MANT_W > 12) begin : g_bad_width
        $error("MEAS_W must be MANT_W + 7, MANT_W in 8..12");
    end

    // ----------------------------------------
    // Software-visible state
    // ----------------------------------------
    logic [7:0]        baud_select_reg;
    logic [7:0]        fine_tx_divider;
    logic [7:0]        fine_rx_divider;
    logic              wakeup_method;
    logic              lin_enable;
    logic              slave_role_select;
    logic              header_detect_method;
    logic              tx_enable;
    logic              rx_enable;
    logic              quiet_line_flag;
    logic              sync_valid;
    logic              hot_plug_found;
    logic [15:0]       lin_divider;

    wire logic         wr_baud  = reg_wr && reg_addr == `SBM_OFS_BAUD;
    wire logic         wr_ftx   = reg_wr && reg_addr == `SBM_OFS_FINE_TX;
    wire logic         wr_frx   = reg_wr && reg_addr == `SBM_OFS_FINE_RX;
    wire logic         wr_ctrl  = reg_wr && reg_addr == `SBM_OFS_CTRL;
    wire logic         wr_stat  = reg_wr && reg_addr == `SBM_OFS_STAT;
    wire logic         wr_ldhi  = reg_wr && reg_addr == `SBM_OFS_LIN_DIVIDER_HI;
    wire logic         wr_ldlo  = reg_wr && reg_addr == `SBM_OFS_LIN_DIVIDER_LO;
    wire logic         lin_slave = lin_enable && slave_role_select;

    // Plain stores; software keeps them still while enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            baud_select_reg <= `SBM_RST_BYTE;
            fine_tx_divider <= `SBM_RST_BYTE;
            fine_rx_divider <= `SBM_RST_BYTE;
        end else begin
            if (wr_baud) baud_select_reg <= reg_wdata;
            if (wr_ftx) fine_tx_divider <= reg_wdata;
            if (wr_frx) fine_rx_divider <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wakeup_method        <= 1'b0;
            lin_enable           <= 1'b0;
            slave_role_select    <= 1'b0;
            header_detect_method <= 1'b0;
            tx_enable            <= 1'b0;
            rx_enable            <= 1'b0;
        end else if (wr_ctrl) begin
            wakeup_method        <= reg_wdata[`SBM_CTRL_WAKE];
            lin_enable           <= reg_wdata[`SBM_CTRL_LINE];
            slave_role_select    <= reg_wdata[`SBM_CTRL_SLAVE];
            header_detect_method <= reg_wdata[`SBM_CTRL_HDM];
            tx_enable            <= reg_wdata[`SBM_CTRL_TXEN];
            rx_enable            <= reg_wdata[`SBM_CTRL_RXEN];
        end
    end

    // ----------------------------------------
    // Divide-by-16 front stage and conventional/fine paths
    // ----------------------------------------
    logic [3:0]        pre16_cnt;
    wire logic         tick16 = pre16_cnt == `SBM_OVS_LAST;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pre16_cnt <= 4'h0;
        else if (lin_slave) pre16_cnt <= 4'h0;
        else pre16_cnt <= pre16_cnt + 4'h1;
    end

    wire logic [1:0]   pr_sel = baud_select_reg[`SBM_BAUD_PR_HI:`SBM_BAUD_PR_LO];
    logic [3:0]        pr_factor;

    always_comb begin
        case (pr_sel)
            2'h0:    pr_factor = `SBM_PR_F0;
            2'h1:    pr_factor = `SBM_PR_F1;
            2'h2:    pr_factor = `SBM_PR_F2;
            default: pr_factor = `SBM_PR_F3;
        endcase
    end

    logic [1:0]        path_tick;
    logic              lin_bit_tick;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_path
            wire logic [7:0] fine = (g == 0) ? fine_tx_divider : fine_rx_divider;
            wire logic [2:0] rsel = (g == 0) ? baud_select_reg[`SBM_BAUD_TX_HI:`SBM_BAUD_TX_LO]
                                             : baud_select_reg[`SBM_BAUD_RX_HI:`SBM_BAUD_RX_LO];
            wire logic [7:0] ratio = 8'h01 << rsel;
            wire logic [13:0] cfg = {lin_slave, fine, pr_sel, rsel};
            logic [13:0]     cfg_q;
            logic [7:0]      fine_cnt;
            logic [3:0]      pr_cnt;
            logic [7:0]      rt_cnt;
            wire logic       chg = cfg != cfg_q;
            // Zero fine value passes every 16-tick straight through
            wire logic       fine_tick = tick16 && (fine == 8'h00 || fine_cnt == fine - 8'h01);
            wire logic       pr_tick = fine_tick && pr_cnt == pr_factor - 4'h1;
            wire logic       rt_tick = pr_tick && rt_cnt == ratio - 8'h01;

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    cfg_q    <= 14'h0000;
                    fine_cnt <= 8'h00;
                    pr_cnt   <= 4'h0;
                    rt_cnt   <= 8'h00;
                end else if (chg || lin_slave) begin
                    cfg_q    <= cfg;
                    fine_cnt <= 8'h00;
                    pr_cnt   <= 4'h0;
                    rt_cnt   <= 8'h00;
                end else begin
                    if (tick16) fine_cnt <= fine_tick ? 8'h00 : fine_cnt + 8'h01;
                    if (fine_tick) pr_cnt <= pr_tick ? 4'h0 : pr_cnt + 4'h1;
                    if (pr_tick) rt_cnt <= rt_tick ? 8'h00 : rt_cnt + 8'h01;
                end
            end

            // LIN slave: measured divider replaces both generators
            assign path_tick[g] = lin_slave ? lin_bit_tick : (rt_tick && !chg);
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_rate_tick <= 1'b0;
            rx_rate_tick <= 1'b0;
        end else begin
            tx_rate_tick <= path_tick[0];
            rx_rate_tick <= path_tick[1];
        end
    end

    // ----------------------------------------
    // LIN divider: mantissa plus sixteenths
    // ----------------------------------------
    wire logic [MANT_W-1:0] ld_mant = lin_divider[MANT_W+3:4];
    wire logic [3:0]   ld_frac = lin_divider[3:0];
    logic [MANT_W-1:0] os_cnt;
    logic [3:0]        frac_acc;
    logic [3:0]        os_bits;
    wire logic [4:0]   frac_sum = {1'b0, frac_acc} + {1'b0, ld_frac};
    // Fraction overflow stretches this period by one cycle
    wire logic [MANT_W:0] os_period = {1'b0, ld_mant} + {{MANT_W{1'b0}}, frac_sum[4]};
    wire logic         os_tick = ld_mant != '0 && {1'b0, os_cnt} == os_period - 1'b1;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            os_cnt   <= '0;
            frac_acc <= 4'h0;
            os_bits  <= 4'h0;
        end else if (!lin_slave) begin
            os_cnt   <= '0;
            frac_acc <= 4'h0;
            os_bits  <= 4'h0;
        end else if (os_tick) begin
            os_cnt   <= '0;
            frac_acc <= frac_sum[3:0];
            os_bits  <= os_bits + 4'h1;
        end else begin
            os_cnt   <= os_cnt + 1'b1;
        end
    end

    assign lin_bit_tick = os_tick && os_bits == `SBM_OVS_LAST;

    // ----------------------------------------
    // Synch field measurement
    // ----------------------------------------
    // Five falls of the 55h field span eight bits; one cycle of slack at each end
    sbm_pkg::sbm_sync_t sync_state;
    sbm_pkg::sbm_sync_t next_sync_state;
    logic              rx_prev;
    logic [2:0]        fall_cnt;
    logic [MEAS_W-1:0] meas_cnt;
    wire logic         rx_fall = rx_prev && !rx_input_line;
    wire logic         meas_done = sync_state == sbm_pkg::SBM_SYNC_COUNT && rx_fall
                                   && fall_cnt == `SBM_SYNC_FALLS - 3'h1;

    always_comb begin
        next_sync_state = sync_state;
        case (sync_state)
            sbm_pkg::SBM_SYNC_ARMED: if (rx_fall) next_sync_state = sbm_pkg::SBM_SYNC_COUNT;
            sbm_pkg::SBM_SYNC_COUNT: if (meas_done) next_sync_state = sbm_pkg::SBM_SYNC_IDLE;
            default:                 next_sync_state = sbm_pkg::SBM_SYNC_IDLE;
        endcase
        // A new break restarts a cut measurement
        if (lin_break_seen) next_sync_state = sbm_pkg::SBM_SYNC_ARMED;
        if (!lin_slave) next_sync_state = sbm_pkg::SBM_SYNC_IDLE;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_state <= sbm_pkg::SBM_SYNC_IDLE;
            rx_prev    <= 1'b1;
            fall_cnt   <= 3'h0;
            meas_cnt   <= '0;
        end else begin
            sync_state <= next_sync_state;
            rx_prev    <= rx_input_line;
            if (sync_state != sbm_pkg::SBM_SYNC_COUNT) begin
                fall_cnt <= 3'h1;
                meas_cnt <= MEAS_W'(1);
            end else begin
                meas_cnt <= meas_cnt + 1'b1;
                if (rx_fall) fall_cnt <= fall_cnt + 3'h1;
            end
        end
    end

    // 128 x divider cycles measured; drop three bits to get sixteenths
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lin_divider <= `SBM_RST_LIN_DIVIDER;
            sync_valid  <= 1'b0;
        end else begin
            if (meas_done) lin_divider <= 16'(meas_cnt[MEAS_W-1:`SBM_MEAS_SHIFT]);
            else if (wr_ldhi) lin_divider[15:8] <= reg_wdata;
            else if (wr_ldlo) lin_divider[7:0] <= reg_wdata;
            if (meas_done) sync_valid <= 1'b1;
            else if (wr_stat && reg_wdata[`SBM_STAT_SYNC]) sync_valid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Hot-plug dominant search
    // ----------------------------------------
    logic [3:0]        dom_cnt;
    wire logic         hot_mode = lin_slave && mute_control;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dom_cnt        <= 4'h0;
            hot_plug_found <= 1'b0;
        end else if (!hot_mode) begin
            dom_cnt        <= 4'h0;
            hot_plug_found <= 1'b0;
        end else if (lin_bit_tick && !hot_plug_found) begin
            if (rx_input_line) dom_cnt <= 4'h0;
            else if (dom_cnt == `SBM_HOT_BITS - 4'h1) hot_plug_found <= 1'b1;
            else dom_cnt <= dom_cnt + 4'h1;
        end
    end

    assign rx_discard = hot_mode && !hot_plug_found;

    // ----------------------------------------
    // Mute and wake-up
    // ----------------------------------------
    wire logic         lin_hdr = header_detect_method ? lin_ident_seen : lin_break_seen;
    wire logic         wake_lin = lin_slave && hot_plug_found && lin_hdr;
    wire logic         wake_idle = !lin_slave && !wakeup_method && rx_idle_frame;
    wire logic         wake_addr = !lin_slave && wakeup_method && rx_word_done && rx_word_msb;
    wire logic         wake = mute_control && (wake_lin || wake_idle || wake_addr);
    wire logic         mute_wr_ok = wr_ctrl && !(wakeup_method && rx_full_flag);
    wire logic         set_full = (rx_word_done && !mute_control) || (mute_control && wake_addr);
    wire logic         set_quiet = rx_idle_frame && !mute_control;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) mute_control <= 1'b0;
        else if (wake) mute_control <= 1'b0;
        else if (mute_wr_ok) mute_control <= reg_wdata[`SBM_CTRL_MUTE];
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_full_flag    <= 1'b0;
            quiet_line_flag <= 1'b0;
        end else begin
            if (set_full) rx_full_flag <= 1'b1;
            else if (wr_stat && reg_wdata[`SBM_STAT_FULL]) rx_full_flag <= 1'b0;
            if (set_quiet) quiet_line_flag <= 1'b1;
            else if (wr_stat && reg_wdata[`SBM_STAT_QUIET]) quiet_line_flag <= 1'b0;
        end
    end

    assign rx_status_enable = !mute_control;
    assign rx_irq_enable    = !mute_control;

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    logic [7:0]        rd_mux;
    wire logic [7:0]   ctrl_rd = {1'b0, rx_enable, tx_enable, header_detect_method,
                                  slave_role_select, lin_enable, wakeup_method, mute_control};
    wire logic [7:0]   stat_rd = {4'h0, hot_plug_found, sync_valid, quiet_line_flag, rx_full_flag};

    always_comb begin
        case (reg_addr)
            `SBM_OFS_BAUD:    rd_mux = baud_select_reg;
            `SBM_OFS_FINE_TX: rd_mux = fine_tx_divider;
            `SBM_OFS_FINE_RX: rd_mux = fine_rx_divider;
            `SBM_OFS_CTRL:    rd_mux = ctrl_rd;
            `SBM_OFS_STAT:    rd_mux = stat_rd;
            `SBM_OFS_LIN_DIVIDER_HI: rd_mux = lin_divider[15:8];
            `SBM_OFS_LIN_DIVIDER_LO: rd_mux = lin_divider[7:0];
            default:          rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) reg_rdata <= 8'h00;
        else if (reg_rd) reg_rdata <= rd_mux;
        else reg_rdata <= 8'h00;
    end

endmodule : sbm_baud_wakeup

// File: bench/sbm_baud_wakeup_asserts.sv
`timescale 1ns/100ps
`include "sbm_map.svh"
module sbm_baud_wakeup_asserts (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       rx_input_line,
    input wire logic       rx_word_done,
    input wire logic       rx_word_msb,
    input wire logic       rx_idle_frame,
    input wire logic       lin_break_seen,
    input wire logic       lin_ident_seen,
    input wire logic       tx_rate_tick,
    input wire logic       rx_rate_tick,
    input wire logic       rx_status_enable,
    input wire logic       rx_irq_enable,
    input wire logic       rx_discard,
    input wire logic       mute_control,
    input wire logic       rx_full_flag
);
    // Control bits mirrored from writes
    logic wake_m;
    logic lin_slv;
    wire  ctrl_wr = reg_wr && reg_addr == `SBM_OFS_CTRL;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_m  <= 1'b0;
            lin_slv <= 1'b0;
        end else if (ctrl_wr) begin
            wake_m  <= reg_wdata[`SBM_CTRL_WAKE];
            lin_slv <= reg_wdata[`SBM_CTRL_LINE] && reg_wdata[`SBM_CTRL_SLAVE];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence tx_quiet; !tx_rate_tick [*8]; endsequence
    sequence rx_quiet; !rx_rate_tick [*8]; endsequence
    // Software mute writes left out
    sequence plain_mute; mute_control && !lin_slv && !ctrl_wr; endsequence
    status_mute_a: assert property (rx_status_enable == !mute_control)
        else $error("status enable not tied to mute");
    irq_mute_a: assert property (rx_irq_enable == !mute_control)
        else $error("irq enable not tied to mute");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    idle_wake_a: assert property (plain_mute ##0 (rx_idle_frame && !wake_m) |=> !mute_control)
        else $error("idle frame did not wake");
    addr_wake_a: assert property (plain_mute ##0 (rx_word_done && rx_word_msb && wake_m)
        |=> !mute_control && rx_full_flag)
        else $error("address mark did not wake");
    addr_hold_a: assert property (plain_mute ##0 (wake_m && !(rx_word_done && rx_word_msb)) |=> mute_control)
        else $error("woke without address mark");
    mute_lock_a: assert property (rx_full_flag && wake_m && !mute_control && ctrl_wr
        && reg_wdata[`SBM_CTRL_MUTE] |=> !mute_control)
        else $error("mute written while full");
    discard_mode_a: assert property (rx_discard |-> mute_control && lin_slv)
        else $error("discard outside slave mute");
    tx_gap_a: assert property (tx_rate_tick |=> tx_quiet)
        else $error("tx ticks too close");
    rx_gap_a: assert property (rx_rate_tick |=> rx_quiet)
        else $error("rx ticks too close");
endmodule : sbm_baud_wakeup_asserts

bind sbm_baud_wakeup sbm_baud_wakeup_asserts u_sbm_baud_wakeup_asserts (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_input_line(rx_input_line), .rx_word_done(rx_word_done),
    .rx_word_msb(rx_word_msb), .rx_idle_frame(rx_idle_frame), .lin_break_seen(lin_break_seen),
    .lin_ident_seen(lin_ident_seen), .tx_rate_tick(tx_rate_tick), .rx_rate_tick(rx_rate_tick),
    .rx_status_enable(rx_status_enable), .rx_irq_enable(rx_irq_enable), .rx_discard(rx_discard),
    .mute_control(mute_control), .rx_full_flag(rx_full_flag));

// File: bench/sbm_lin_node.sv
`timescale 1ns/100ps
// Other node on the bus; line is driven recessive high when idle
module sbm_lin_node (
    input  wire logic clk,
    output logic      line
);
    initial line = 1'b1;
    task drive(input logic v, input int n);
        @(posedge clk);
        line <= v;
        repeat (n - 1) @(posedge clk);
    endtask : drive
    // Start bit, eight data bits LSB first, stop bit, each n cycles
    task send_byte(input logic [7:0] b, input int n);
        drive(1'b0, n);
        for (int i = 0; i < 8; i++) begin
            drive(b[i], n);
        end
        drive(1'b1, n);
    endtask : send_byte
endmodule : sbm_lin_node

// File: bench/sbm_baud_wakeup_tb.sv
`timescale 1ns/100ps
`include "sbm_map.svh"
module sbm_baud_wakeup_tb;
    logic       clk, reset_n, reg_wr, reg_rd, rx_input_line, rx_word_done, rx_word_msb, rx_idle_frame;
    logic       lin_break_seen, lin_ident_seen, tx_rate_tick, rx_rate_tick, rx_status_enable, rx_irq_enable;
    logic       rx_discard, mute_control, rx_full_flag;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    int         errors;
    int         n_checks;

    sbm_baud_wakeup u_sbm_baud_wakeup (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_input_line(rx_input_line), .rx_word_done(rx_word_done),
        .rx_word_msb(rx_word_msb), .rx_idle_frame(rx_idle_frame), .lin_break_seen(lin_break_seen),
        .lin_ident_seen(lin_ident_seen), .tx_rate_tick(tx_rate_tick), .rx_rate_tick(rx_rate_tick),
        .rx_status_enable(rx_status_enable), .rx_irq_enable(rx_irq_enable), .rx_discard(rx_discard),
        .mute_control(mute_control), .rx_full_flag(rx_full_flag));
    sbm_lin_node u_sbm_lin_node (.clk(clk), .line(rx_input_line));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
    task ev(input int k, input logic msb);
        @(posedge clk);
        case (k)
            0: rx_idle_frame <= 1'b1;
            1: begin
                rx_word_done <= 1'b1;
                rx_word_msb  <= msb;
            end
            2: lin_break_seen <= 1'b1;
            default: lin_ident_seen <= 1'b1;
        endcase
        @(posedge clk);
        {rx_idle_frame, rx_word_done, lin_break_seen, lin_ident_seen} <= 4'h0;
        @(negedge clk);
    endtask : ev
    // Distance between two consecutive ticks
    task per(input logic rx, input int exp);
        int i;
        int n;
        i = 0;
        n = 0;
        while ((rx ? rx_rate_tick : tx_rate_tick) !== 1'b1 && i < 40000) begin
            @(negedge clk);
            i++;
        end
        do begin
            @(negedge clk);
            n++;
        end while ((rx ? rx_rate_tick : tx_rate_tick) !== 1'b1 && n < 40000);
        chk(n[15:0], exp[15:0], rx ? "rx period" : "tx period");
        if (i >= 40000 || n >= 40000) begin
            errors++;
            give_verdict();
        end
    endtask : per

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset();
        rd(`SBM_OFS_BAUD, v);    chk(v, 8'h00, "baud reset");
        rd(`SBM_OFS_FINE_TX, v); chk(v, 8'h00, "fine tx reset");
        rd(`SBM_OFS_FINE_RX, v); chk(v, 8'h00, "fine rx reset");
        rd(`SBM_OFS_LIN_DIVIDER_HI, v); chk(v, 8'h01, "lin_divider hi reset");
        rd(`SBM_OFS_LIN_DIVIDER_LO, v); chk(v, 8'h90, "lin_divider lo reset");
        rd(4'hF, v);             chk(v, 8'h00, "unmapped read");
        chk(rx_status_enable, 1'b1, "status enable after reset");
        $display("test reset done");
    endtask : t_reset
    // Enables stay clear while rates change
    task rate_row(input logic [7:0] b, input logic [7:0] ft, input logic [7:0] fr, input int et, input int er);
        wr(`SBM_OFS_BAUD, b);
        wr(`SBM_OFS_FINE_TX, ft);
        wr(`SBM_OFS_FINE_RX, fr);
        per(1'b0, et);
        per(1'b1, er);
    endtask : rate_row
    task t_rates();
        rate_row(8'h00, 8'h00, 8'h00, 16, 16);
        rate_row(8'h48, 8'h00, 8'h03, 96, 144);
        rate_row(8'h87, 8'h00, 8'h00, 64, 8192);
        rate_row(8'h40, 8'hFF, 8'h01, 12240, 48);
        rate_row(8'hC0, 8'h00, 8'h00, 208, 208);
        $display("test rates done");
    endtask : t_rates
    task t_mute_idle();
        wr(`SBM_OFS_CTRL, 8'h01);
        chk({mute_control, rx_status_enable, rx_irq_enable}, 3'b100, "mute gates");
        ev(0, 1'b0);
        chk(mute_control, 1'b0, "idle wake");
        rd(`SBM_OFS_STAT, v); chk(v[1], 1'b0, "quiet flag on wake");
        ev(0, 1'b0);
        rd(`SBM_OFS_STAT, v); chk(v[1], 1'b1, "quiet flag awake");
        $display("test mute idle done");
    endtask : t_mute_idle
    task t_mute_addr();
        wr(`SBM_OFS_STAT, 8'h07);
        wr(`SBM_OFS_CTRL, 8'h03);
        ev(1, 1'b0);
        chk({mute_control, rx_full_flag}, 2'b10, "no mark stays muted");
        ev(1, 1'b1);
        chk({mute_control, rx_full_flag}, 2'b01, "mark wakes");
        wr(`SBM_OFS_CTRL, 8'h03);
        chk(mute_control, 1'b0, "mute locked while full");
        wr(`SBM_OFS_STAT, 8'h01);
        wr(`SBM_OFS_CTRL, 8'h03);
        chk(mute_control, 1'b1, "mute after clear");
        $display("test mute address done");
    endtask : t_mute_addr
    task t_hotplug();
        wr(`SBM_OFS_LIN_DIVIDER_HI, 8'h00);
        wr(`SBM_OFS_LIN_DIVIDER_LO, 8'h10);
        wr(`SBM_OFS_CTRL, 8'h0D);
        u_sbm_lin_node.drive(1'b0, 160);
        u_sbm_lin_node.drive(1'b1, 32);
        @(negedge clk);
        chk(rx_discard, 1'b1, "ten dominant bits");
        ev(2, 1'b0);
        chk(mute_control, 1'b1, "break before search ends");
        u_sbm_lin_node.drive(1'b0, 192);
        u_sbm_lin_node.drive(1'b1, 4);
        @(negedge clk);
        chk(rx_discard, 1'b0, "eleven dominant bits");
        rd(`SBM_OFS_STAT, v); chk(v[3], 1'b1, "hot plug found");
        ev(3, 1'b0);
        chk(mute_control, 1'b1, "identifier ignored");
        ev(2, 1'b0);
        chk(mute_control, 1'b0, "break wakes");
        wr(`SBM_OFS_CTRL, 8'h1D);
        u_sbm_lin_node.drive(1'b0, 192);
        u_sbm_lin_node.drive(1'b1, 4);
        ev(2, 1'b0);
        chk(mute_control, 1'b1, "break ignored");
        ev(3, 1'b0);
        chk(mute_control, 1'b0, "identifier wakes");
        $display("test hot plug done");
    endtask : t_hotplug
    task t_sync();
        wr(`SBM_OFS_CTRL, 8'h0C);
        ev(2, 1'b0);
        u_sbm_lin_node.send_byte(8'h55, 40);
        rd(`SBM_OFS_LIN_DIVIDER_HI, v); chk(v, 8'h00, "measured hi");
        rd(`SBM_OFS_LIN_DIVIDER_LO, v); chk(v == 8'h28 || v == 8'h27, 1'b1, "measured lo");
        rd(`SBM_OFS_STAT, v); chk(v[2], 1'b1, "sync valid");
        per(1'b1, 40);
        $display("test sync done");
    endtask : t_sync

    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {rx_word_done, rx_word_msb, rx_idle_frame, lin_break_seen, lin_ident_seen} = '0;
        errors   = 0;
        n_checks = 0;
        reset_n  = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_rates();
        t_mute_idle();
        t_mute_addr();
        t_hotplug();
        t_sync();
        give_verdict();
    end
endmodule : sbm_baud_wakeup_tb
